//--- rtl/acr_config.sv
// channel select and input range configuration registers with result self test
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_config
	import acr_pkg::*;
#(
	parameter int ADDR_W = `ACR_ADDR_W,
	parameter int DATA_W = `ACR_DATA_W,
	parameter int NUM_IN = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [DATA_W-1:0] conv_a_raw,
	input wire logic [DATA_W-1:0] conv_b_raw,
	input wire logic conv_raw_valid,
	output logic [DATA_W-1:0] conv_a_result,
	output logic [DATA_W-1:0] conv_b_result,
	output logic conv_result_valid,
	output logic [3:0] conv_a_input_sel,
	output logic [3:0] conv_b_input_sel,
	output acr_chan_kind_t conv_a_chan_kind,
	output acr_chan_kind_t conv_b_chan_kind,
	output acr_range_t conv_a_range [NUM_IN],
	output acr_range_t conv_b_range [NUM_IN]
);
	localparam int PW = `ACR_PAYLOAD_W;
	localparam int FW = 2 * NUM_IN;

	// classify a 4-bit channel code; shared by both converters
	function automatic acr_chan_kind_t chan_kind(input logic [3:0] code);
		acr_chan_kind_t k;
		k = ACR_CH_RESERVED;
		if (code <= `ACR_CODE_LAST_INPUT) begin
			k = ACR_CH_INPUT;
		end else if (code == `ACR_CODE_SUPPLY) begin
			k = ACR_CH_SUPPLY;
		end else if (code == `ACR_CODE_REGULATOR) begin
			k = ACR_CH_REGULATOR;
		end else if (code == `ACR_CODE_SELFTEST) begin
			k = ACR_CH_SELFTEST;
		end
		return k;
	endfunction

	// stored payloads, bits 8:0 of each word
	logic [PW-1:0] chan_reg;
	logic [PW-1:0] ra1_reg;
	logic [PW-1:0] ra2_reg;
	logic [PW-1:0] rb1_reg;
	logic [PW-1:0] rb2_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] a_result_reg;
	logic [DATA_W-1:0] b_result_reg;
	logic result_valid_reg;
	acr_chan_kind_t a_kind_reg;
	acr_chan_kind_t b_kind_reg;
	acr_range_t a_range_reg [NUM_IN];
	acr_range_t b_range_reg [NUM_IN];
	logic ra1_touched_reg;

	// address decode
	wire logic sel_chan;
	wire logic sel_ra1;
	wire logic sel_ra2;
	wire logic sel_rb1;
	wire logic sel_rb2;
	wire logic rd_hit;
	wire logic [PW-1:0] wr_payload;
	wire logic [PW-1:0] rd_payload;
	wire logic [DATA_W-1:0] rdata_next;

	assign sel_chan = (reg_addr == `ACR_ADDR_CHAN); // [R10]
	assign sel_ra1 = (reg_addr == `ACR_ADDR_RA1); // [R6]
	assign sel_ra2 = (reg_addr == `ACR_ADDR_RA2);
	assign sel_rb1 = (reg_addr == `ACR_ADDR_RB1);
	assign sel_rb2 = (reg_addr == `ACR_ADDR_RB2);
	assign rd_hit = sel_chan | sel_ra1 | sel_ra2 | sel_rb1 | sel_rb2;
	assign wr_payload = reg_wdata[PW-1:0];
	assign rd_payload = sel_chan ? chan_reg :
		sel_ra1 ? ra1_reg :
		sel_ra2 ? ra2_reg :
		sel_rb1 ? rb1_reg :
		sel_rb2 ? rb2_reg : `ACR_CHAN_RESET;
	// the word read back carries its own address in the top bits [R7]
	assign rdata_next = (reg_rd && rd_hit) ? {reg_addr, rd_payload} : '0;

	// field views
	wire logic [3:0] conv_a_sel_field;
	wire logic [3:0] conv_b_sel_field;
	wire logic [1:0] conv_a_in0_range;
	wire logic [1:0] conv_a_in1_range;
	wire logic [1:0] conv_a_in2_range;
	wire logic [1:0] conv_a_in3_range;
	wire logic [FW-1:0] a_fields;
	wire logic [FW-1:0] b_fields;
	wire acr_chan_kind_t a_kind_next;
	wire acr_chan_kind_t b_kind_next;
	wire logic a_selftest;
	wire logic b_selftest;

	assign conv_a_sel_field = chan_reg[`ACR_CHA_HI:`ACR_CHA_LO]; // [R1]
	assign conv_b_sel_field = chan_reg[`ACR_CHB_HI:`ACR_CHB_LO];
	assign conv_a_in0_range = ra1_reg[1:0]; // [R8]
	assign conv_a_in1_range = ra1_reg[3:2]; // [R8]
	assign conv_a_in2_range = ra1_reg[5:4]; // [R8]
	assign conv_a_in3_range = ra1_reg[7:6]; // [R8]
	// low register serves inputs 0..3, high register inputs 4..7 [R4] [R5]
	assign a_fields = {ra2_reg[`ACR_RNG_FIELDS_HI:`ACR_RNG_FIELDS_LO],
		conv_a_in3_range, conv_a_in2_range, conv_a_in1_range, conv_a_in0_range};
	assign b_fields = {rb2_reg[`ACR_RNG_FIELDS_HI:`ACR_RNG_FIELDS_LO],
		rb1_reg[`ACR_RNG_FIELDS_HI:`ACR_RNG_FIELDS_LO]};
	assign a_kind_next = chan_kind(conv_a_sel_field); // [R2] [R12]
	assign b_kind_next = chan_kind(conv_b_sel_field);
	assign a_selftest = (conv_a_sel_field == `ACR_CODE_SELFTEST);
	assign b_selftest = (conv_b_sel_field == `ACR_CODE_SELFTEST);

	// per-input range decode
	acr_range_t a_range_next [NUM_IN];
	acr_range_t b_range_next [NUM_IN];
	for (genvar i = 0; i < NUM_IN; i++) begin : g_rng
		acr_range_decode u_dec_a (
			.code(a_fields[2*i+1:2*i]),
			.range(a_range_next[i])
		);
		acr_range_decode u_dec_b (
			.code(b_fields[2*i+1:2*i]),
			.range(b_range_next[i])
		);
	end

	// register file; reserved codes are stored as written [R12]
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			chan_reg <= `ACR_CHAN_RESET; // [R1] [R10]
			ra1_reg <= `ACR_RANGE_RESET; // [R6] [R8]
			ra2_reg <= `ACR_RANGE_RESET;
			rb1_reg <= `ACR_RANGE_RESET;
			rb2_reg <= `ACR_RANGE_RESET;
		end else if (reg_wr) begin
			if (sel_chan) chan_reg <= wr_payload;
			if (sel_ra1) ra1_reg <= wr_payload;
			if (sel_ra2) ra2_reg <= wr_payload;
			if (sel_rb1) rb1_reg <= wr_payload;
			if (sel_rb2) rb2_reg <= wr_payload;
		end
	end

	// read data stands for exactly one cycle after the strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// conversion results, with the fixed self test patterns substituted
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			a_result_reg <= '0;
			b_result_reg <= '0;
			result_valid_reg <= 1'b0;
		end else begin
			result_valid_reg <= conv_raw_valid;
			if (conv_raw_valid) begin
				a_result_reg <= a_selftest ? `ACR_PATTERN_A : conv_a_raw; // [R3]
				b_result_reg <= b_selftest ? `ACR_PATTERN_B : conv_b_raw; // [R11]
			end
		end
	end

	// decoded configuration, registered for the datapath
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			a_kind_reg <= ACR_CH_INPUT;
			b_kind_reg <= ACR_CH_INPUT;
			for (int i = 0; i < NUM_IN; i++) begin
				a_range_reg[i] <= ACR_RNG_10V;
				b_range_reg[i] <= ACR_RNG_10V;
			end
		end else begin
			a_kind_reg <= a_kind_next;
			b_kind_reg <= b_kind_next;
			for (int i = 0; i < NUM_IN; i++) begin
				a_range_reg[i] <= a_range_next[i]; // [R4] [R9]
				b_range_reg[i] <= b_range_next[i]; // [R5] [R9]
			end
		end
	end

	// remembers whether the low A range word was ever written since reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ra1_touched_reg <= 1'b0;
		end else if (reg_wr && sel_ra1) begin
			ra1_touched_reg <= 1'b1;
		end
	end

	assign reg_rdata = rdata_reg;
	assign conv_a_result = a_result_reg;
	assign conv_b_result = b_result_reg;
	assign conv_result_valid = result_valid_reg;
	assign conv_a_input_sel = chan_reg[`ACR_CHA_HI:`ACR_CHA_LO];
	assign conv_b_input_sel = chan_reg[`ACR_CHB_HI:`ACR_CHB_LO];
	assign conv_a_chan_kind = a_kind_reg;
	assign conv_b_chan_kind = b_kind_reg;
	assign conv_a_range = a_range_reg;
	assign conv_b_range = b_range_reg;

	property p_chan_write;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_chan) |=> (conv_a_input_sel == $past(reg_wdata[3:0]));
	endproperty
	a_chan_write: assert property (p_chan_write) // [R1]
		else $error("channel A select did not take the written value");

	property p_input_kind;
		@(posedge sys_clk) disable iff (!nrst)
		(conv_a_input_sel <= `ACR_CODE_LAST_INPUT) |=> (conv_a_chan_kind == ACR_CH_INPUT);
	endproperty
	a_input_kind: assert property (p_input_kind) // [R2]
		else $error("channel A input code not classed as an analog input");

	property p_selftest_a;
		@(posedge sys_clk) disable iff (!nrst)
		(conv_raw_valid && conv_a_input_sel == `ACR_CODE_SELFTEST)
			|=> (conv_a_result == `ACR_PATTERN_A) && conv_result_valid;
	endproperty
	a_selftest_a: assert property (p_selftest_a) // [R3]
		else $error("converter A self test pattern missing");

	property p_range_a_high;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_ra2 && reg_wdata[1:0] == `ACR_RC_2V5) ##1 !(reg_wr && sel_ra2)
			|-> ##1 (conv_a_range[4] == ACR_RNG_2V5);
	endproperty
	a_range_a_high: assert property (p_range_a_high) // [R4]
		else $error("converter A input 4 range not set from high register");

	property p_range_b_low;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_rb1 && reg_wdata[1:0] == `ACR_RC_5V) ##1 !(reg_wr && sel_rb1)
			|-> ##1 (conv_b_range[0] == ACR_RNG_5V);
	endproperty
	a_range_b_low: assert property (p_range_b_low) // [R5]
		else $error("converter B input 0 range not set from low register");

	property p_ra1_reset;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && sel_ra1 && !ra1_touched_reg)
			|=> (reg_rdata == {`ACR_ADDR_RA1, `ACR_RANGE_RESET});
	endproperty
	a_ra1_reset: assert property (p_ra1_reset) // [R6]
		else $error("low A range register lost its reset value");

	property p_read_addr;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && rd_hit) |=>
			(reg_rdata[`ACR_WORD_ADDR_HI:`ACR_WORD_ADDR_LO] == $past(reg_addr))
			##1 (reg_rdata == '0 || $past(reg_rd));
	endproperty
	a_read_addr: assert property (p_read_addr) // [R7]
		else $error("read word does not carry its address or overstays");

	property p_field_pos;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_ra1) |=> (conv_a_in3_range == $past(reg_wdata[7:6]))
			&& (conv_a_in0_range == $past(reg_wdata[1:0]));
	endproperty
	a_field_pos: assert property (p_field_pos) // [R8]
		else $error("low A range fields misplaced");

	property p_wide_code;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_ra1 && reg_wdata[7:6] == `ACR_RC_10V_LO) ##1 !(reg_wr && sel_ra1)
			|-> ##1 (conv_a_range[3] == ACR_RNG_10V);
	endproperty
	a_wide_code: assert property (p_wide_code) // [R9]
		else $error("range code 00 not decoded as widest range");

	property p_chan_read;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && sel_chan) |=> (reg_rdata[3:0] == $past(conv_a_input_sel))
			&& (reg_rdata[`ACR_WORD_ADDR_HI:`ACR_WORD_ADDR_LO] == `ACR_ADDR_CHAN);
	endproperty
	a_chan_read: assert property (p_chan_read) // [R10]
		else $error("channel select read back wrong");

	property p_selftest_b;
		@(posedge sys_clk) disable iff (!nrst)
		(conv_raw_valid && conv_b_input_sel == `ACR_CODE_SELFTEST)
			|=> (conv_b_result == `ACR_PATTERN_B);
	endproperty
	a_selftest_b: assert property (p_selftest_b) // [R11]
		else $error("converter B self test pattern missing");

	property p_reserved;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_chan && reg_wdata[3:0] == `ACR_CODE_RESERVED_A)
			##1 !(reg_wr && sel_chan)
			|-> (conv_a_input_sel == `ACR_CODE_RESERVED_A)
			##1 (conv_a_chan_kind == ACR_CH_RESERVED);
	endproperty
	a_reserved: assert property (p_reserved) // [R12]
		else $error("reserved channel code not stored or not flagged");

	property p_supply_kind;
		@(posedge sys_clk) disable iff (!nrst)
		(conv_a_input_sel == `ACR_CODE_SUPPLY) |=> (conv_a_chan_kind == ACR_CH_SUPPLY);
	endproperty
	a_supply_kind: assert property (p_supply_kind) // [R2]
		else $error("channel A supply code not classed as supply monitor");

	property p_regulator_kind;
		@(posedge sys_clk) disable iff (!nrst)
		(conv_a_input_sel == `ACR_CODE_REGULATOR) |=> (conv_a_chan_kind == ACR_CH_REGULATOR);
	endproperty
	a_regulator_kind: assert property (p_regulator_kind) // [R2]
		else $error("channel A regulator code not classed as regulator");

	property p_b_chan_write;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_chan) |=> (conv_b_input_sel == $past(reg_wdata[7:4]));
	endproperty
	a_b_chan_write: assert property (p_b_chan_write) // [R10]
		else $error("channel B select did not take the written value");

	property p_unmapped_read;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && !rd_hit) |=> (reg_rdata == '0);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) // [R7]
		else $error("read of an unmapped address returned data");

	property p_range_b_high;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_rb2 && reg_wdata[7:6] == `ACR_RC_2V5) ##1 !(reg_wr && sel_rb2)
			|-> ##1 (conv_b_range[7] == ACR_RNG_2V5);
	endproperty
	a_range_b_high: assert property (p_range_b_high) // [R5]
		else $error("converter B input 7 range not set from high register");

	property p_range_a_mid;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && sel_ra1 && reg_wdata[3:2] == `ACR_RC_5V) ##1 !(reg_wr && sel_ra1)
			|-> ##1 (conv_a_range[1] == ACR_RNG_5V);
	endproperty
	a_range_a_mid: assert property (p_range_a_mid) // [R9]
		else $error("range code 10 on input 1 not decoded as 5 V range");
endmodule

//--- rtl/acr_defs.svh
// constants for the converter channel and input range configuration registers
//
// Contract
// R1: Bits 3:0 of the channel select register choose the converter A input; they reset to zero and can be read and written.
// R2: Converter A channel codes 0 to 7 pick inputs zero to seven, 8 picks the supply monitor and 9 the internal regulator, as for converter B.
// R3: Converter A channel code 1011 makes converter A's result read as the fixed word 0xAAAA for an interface self test.
// R4: The two converter A range registers together set one of three ranges for each of the eight converter A inputs.
// R5: The two converter B range registers together set one of three ranges for each of the eight converter B inputs.
// R6: The first converter A range register sits at address 0x04 and resets to 0x00FF, the widest range on all its inputs.
// R7: Every configuration word carries the register address in bits 15:9, put there by the host on writes and by the device on reads.
// R8: The first converter A range register holds input three at bits 7:6, two at 5:4, one at 3:2 and zero at 1:0, each resetting to 3.
// R9: A range field of 00 or 11 means plus or minus 10 V, 01 means 2.5 V and 10 means 5 V.
// R10: The channel select register sits at address 0x03, resets to 0x0000 and picks the channel or self test for the next conversion.
// R11: Converter B channel code 1011 in bits 7:4 makes converter B's result read as the fixed word 0x5555.
// R12: A reserved channel code is stored as written but gives no defined conversion result.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_ADDR_W 7
`define ACR_DATA_W 16
`define ACR_PAYLOAD_W 9
`define ACR_WORD_ADDR_HI 15
`define ACR_WORD_ADDR_LO 9

`define ACR_ADDR_CHAN 7'h03
`define ACR_ADDR_RA1 7'h04
`define ACR_ADDR_RA2 7'h05
`define ACR_ADDR_RB1 7'h06
`define ACR_ADDR_RB2 7'h07

`define ACR_CHAN_RESET 9'h000
`define ACR_RANGE_RESET 9'h0FF

`define ACR_CHA_HI 3
`define ACR_CHA_LO 0
`define ACR_CHB_HI 7
`define ACR_CHB_LO 4
`define ACR_RNG_FIELDS_HI 7
`define ACR_RNG_FIELDS_LO 0

`define ACR_CODE_LAST_INPUT 4'h7
`define ACR_CODE_SUPPLY 4'h8
`define ACR_CODE_REGULATOR 4'h9
`define ACR_CODE_SELFTEST 4'hB
`define ACR_CODE_RESERVED_A 4'hA

`define ACR_PATTERN_A 16'hAAAA
`define ACR_PATTERN_B 16'h5555

`define ACR_RC_10V_LO 2'h0
`define ACR_RC_2V5 2'h1
`define ACR_RC_5V 2'h2
`define ACR_RC_10V_HI 2'h3

`endif

//--- rtl/acr_pkg.sv
// types shared by the channel and range configuration logic
package acr_pkg;
	typedef enum logic [1:0] {
		ACR_RNG_10V,
		ACR_RNG_5V,
		ACR_RNG_2V5
	} acr_range_t;

	typedef enum logic [2:0] {
		ACR_CH_INPUT,
		ACR_CH_SUPPLY,
		ACR_CH_REGULATOR,
		ACR_CH_SELFTEST,
		ACR_CH_RESERVED
	} acr_chan_kind_t;
endpackage

//--- rtl/acr_range_decode.sv
// decode of one 2-bit input range field into its range class
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_range_decode
	import acr_pkg::*;
(
	input wire logic [1:0] code,
	output acr_range_t range
);
	wire logic is_2v5;
	wire logic is_5v;

	assign is_2v5 = (code == `ACR_RC_2V5);
	assign is_5v = (code == `ACR_RC_5V);
	// both remaining codes select the widest range [R9]
	assign range = is_2v5 ? ACR_RNG_2V5 : (is_5v ? ACR_RNG_5V : ACR_RNG_10V);
endmodule

//--- dv/acr_host_model.sv
// host model driving the register bus and the raw conversion words
`timescale 1ns/1ps
module acr_host_model (
	input wire logic sys_clk,
	output logic [6:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] conv_a_raw,
	output logic [15:0] conv_b_raw,
	output logic conv_raw_valid
);
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		conv_a_raw = 16'h0000;
		conv_b_raw = 16'h0000;
		conv_raw_valid = 1'b0;
	end
	// one bus cycle; the word carries its own address on top
	task automatic bus(input logic wr, input logic rd, input logic [6:0] a, input logic [8:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= {a, d};
		reg_wr <= wr;
		reg_rd <= rd;
		conv_raw_valid <= 1'b0;
	endtask
	task automatic sample(input logic [15:0] a, input logic [15:0] b);
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		conv_a_raw <= a;
		conv_b_raw <= b;
		conv_raw_valid <= 1'b1;
	endtask
	// strobes drop low; address, data and raw lines show the inverse of their last value
	task automatic idle();
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		conv_raw_valid <= 1'b0;
		reg_addr <= ~reg_addr;
		reg_wdata <= ~reg_wdata;
		conv_a_raw <= ~conv_a_raw;
		conv_b_raw <= ~conv_b_raw;
	endtask
endmodule

//--- dv/acr_config_bench.sv
// self-checking bench for the channel and input range registers
`timescale 1ns/1ps
module acr_config_bench
	import acr_pkg::*;
;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [6:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, conv_a_raw, conv_b_raw, conv_a_result, conv_b_result;
	logic reg_wr, reg_rd, conv_raw_valid, conv_result_valid;
	logic [3:0] conv_a_input_sel, conv_b_input_sel;
	acr_chan_kind_t conv_a_chan_kind, conv_b_chan_kind;
	acr_range_t conv_a_range [8];
	acr_range_t conv_b_range [8];
	int fails = 0;
	int tests_run = 0;
	int seed = 74;
	logic [15:0] rd_q [$];
	logic [31:0] res_q [$];
	logic [8:0] mirror [128];
	logic rd_flag = 1'b0;
	logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
		4'hB, 4'hA, 4'hC};

	always #10 sys_clk = ~sys_clk;

	acr_host_model acr_host_model_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.conv_a_raw, .conv_b_raw, .conv_raw_valid);
	acr_config acr_config_i (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .conv_a_raw, .conv_b_raw, .conv_raw_valid, .conv_a_result, .conv_b_result,
		.conv_result_valid, .conv_a_input_sel, .conv_b_input_sel, .conv_a_chan_kind,
		.conv_b_chan_kind, .conv_a_range, .conv_b_range);

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	function automatic acr_range_t rng_of(input logic [1:0] c);
		case (c)
			2'h1: return ACR_RNG_2V5;
			2'h2: return ACR_RNG_5V;
			default: return ACR_RNG_10V;
		endcase
	endfunction

	function automatic acr_chan_kind_t kind_of(input logic [3:0] c);
		if (c < 4'h8) return ACR_CH_INPUT;
		if (c == 4'h8) return ACR_CH_SUPPLY;
		if (c == 4'h9) return ACR_CH_REGULATOR;
		if (c == 4'hB) return ACR_CH_SELFTEST;
		return ACR_CH_RESERVED;
	endfunction

	function automatic logic mapped(input logic [6:0] a);
		return a >= 7'h03 && a <= 7'h07;
	endfunction

	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		if (mapped(a)) mirror[a] = d;
		acr_host_model_i.bus(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [6:0] a);
		rd_q.push_back(mapped(a) ? {a, mirror[a]} : 16'h0000);
		acr_host_model_i.bus(1'b0, 1'b1, a, 9'h000);
	endtask

	// reserved codes have no defined result, so no sample is taken then
	task automatic smp(input logic [15:0] a, input logic [15:0] b);
		if (kind_of(mirror[3][3:0]) == ACR_CH_RESERVED) return;
		if (kind_of(mirror[3][7:4]) == ACR_CH_RESERVED) return;
		res_q.push_back({(mirror[3][3:0] == 4'hB) ? 16'hAAAA : a,
			(mirror[3][7:4] == 4'hB) ? 16'h5555 : b});
		acr_host_model_i.sample(a, b);
	endtask

	task automatic rd_all();
		for (int a = 2; a < 9; a++) rd(7'(a));
		rd(7'h7F);
	endtask

	task automatic settle();
		acr_host_model_i.idle();
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic do_reset();
		nrst <= 1'b0;
		mirror[3] = 9'h000;
		for (int a = 4; a < 8; a++) mirror[a] = 9'h0FF;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask

	task automatic check_outs();
		for (int i = 0; i < 4; i++) begin
			check("a low range", conv_a_range[i], rng_of(mirror[4][2*i+:2]));
			check("a high range", conv_a_range[i+4], rng_of(mirror[5][2*i+:2]));
			check("b low range", conv_b_range[i], rng_of(mirror[6][2*i+:2]));
			check("b high range", conv_b_range[i+4], rng_of(mirror[7][2*i+:2]));
		end
		check("a select", conv_a_input_sel, mirror[3][3:0]);
		check("b select", conv_b_input_sel, mirror[3][7:4]);
		check("a kind", conv_a_chan_kind, kind_of(mirror[3][3:0]));
		check("b kind", conv_b_chan_kind, kind_of(mirror[3][7:4]));
	endtask

	// read data stand in the cycle after the strobe, zero otherwise
	always @(negedge sys_clk) begin
		if (rd_flag && rd_q.size() == 0) begin
			check("read queue", 32'h1, 32'h0);
		end else if (rd_flag) begin
			check("reg_rdata", reg_rdata, rd_q.pop_front());
		end else begin
			check("idle reg_rdata", reg_rdata, 16'h0000);
		end
		rd_flag = reg_rd;
		if (conv_result_valid === 1'b1 && res_q.size() == 0) begin
			check("result queue", 32'h1, 32'h0);
		end else if (conv_result_valid === 1'b1) begin
			check("results", {conv_a_result, conv_b_result}, res_q.pop_front());
		end
	end

	initial begin
		do_reset();
		rd_all();
		settle();
		check_outs();
		for (int i = 0; i < 13; i++) begin
			wr(7'h03, {1'($random(seed)), codes[(i+5)%13], codes[i]});
			for (int a = 4; a < 8; a++) wr(7'(a), 9'($random(seed)));
			wr(7'h40, 9'($random(seed)));
			settle();
			check_outs();
			rd_all();
			smp(16'($random(seed)), 16'($random(seed)));
			smp(16'($random(seed)), 16'($random(seed)));
			acr_host_model_i.idle();
		end
		// let the last results land before the mid-run reset clears them
		settle();
		do_reset();
		rd_all();
		settle();
		check_outs();
		for (int n = 0; n < 10 && (rd_q.size() != 0 || res_q.size() != 0); n++) begin
			@(posedge sys_clk);
		end
		if (rd_q.size() != 0 || res_q.size() != 0) begin
			check("pending answers", 32'h1, 32'h0);
		end
		complete_run();
	end
endmodule
